// File: psram_port_pkg.sv
`default_nettype none
package psram_port_pkg;
	// Clocking of the bus, derived by the host from its own clock
	localparam int MCLK_PERIOD_NS = 40;
	localparam int BUS_PERIOD_NS = 320;
	localparam int HALF_DIV = BUS_PERIOD_NS / (2 * MCLK_PERIOD_NS);
	localparam logic [1:0] PH_LAST = 2'(HALF_DIV - 1);
	localparam logic [1:0] PH_MID = 2'(HALF_DIV / 2);
	// Transaction framing, counted in bus clock edges
	localparam int EDGE_W = 6;
	localparam logic [5:0] CMD_BYTES = 6'h06;
	localparam logic [5:0] ADDR_BYTE = 6'h05;
	localparam logic [5:0] LAT_SAMPLE = 6'h03;
	localparam int LAT_CLOCKS = 3;
	localparam logic [5:0] LAT1_EDGES = 6'(2 * LAT_CLOCKS);
	localparam logic [5:0] LAT2_EDGES = 6'(4 * LAT_CLOCKS);
	// Command byte fields
	localparam int CMD_RW_BIT = 7;
	localparam int CMD_LINEAR_BIT = 5;
	// Refresh request interval
	localparam int REFRESH_NS = 16000;
	localparam logic [8:0] REFRESH_LAST = 9'(REFRESH_NS / MCLK_PERIOD_NS - 1);
	// Storage
	localparam int ADDR_W = 4;
	localparam int MEM_DEPTH = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_W = 9;
	typedef enum logic [2:0] {D_IDLE, D_CMD, D_LAT, D_READ, D_WRITE} dev_state_t;
	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_RUN, H_DRAIN, H_HOLD, H_GAP} host_state_t;
endpackage
`default_nettype wire

// File: psram_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psram_bus_if;
	logic       cs_n;
	logic       bus_clock_true;
	logic       clock_complement;
	logic       hw_reset_n;
	logic [7:0] dq_host;
	logic       dq_host_oe;
	logic [7:0] dq_dev;
	logic       dq_dev_oe;
	logic       mask_host;
	logic       mask_host_oe;
	logic       strobe_dev;
	logic       strobe_dev_oe;
	logic [7:0] dq;
	logic       strobe_mask_line;
	// Wire levels; an undriven lane reads as a weak high, the strobe as low
	assign dq = dq_dev_oe ? dq_dev : (dq_host_oe ? dq_host : 8'hFF);
	assign strobe_mask_line = strobe_dev_oe ? strobe_dev : (mask_host_oe ? mask_host : 1'b0);
	modport device (
		input  cs_n, bus_clock_true, clock_complement, hw_reset_n, dq, strobe_mask_line,
		output dq_dev, dq_dev_oe, strobe_dev, strobe_dev_oe
	);
	modport host (
		output cs_n, bus_clock_true, clock_complement, hw_reset_n,
		output dq_host, dq_host_oe, mask_host, mask_host_oe,
		input  dq, strobe_mask_line
	);
endinterface
`default_nettype wire

// File: psram_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module psram_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk_i,
	input  wire logic             reset_n_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [AW:0]      count, next_count;
	logic             push, pop;

	assign in_ready_o = (count != (AW + 1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];

	// Pointers wrap naturally, so depth must be a power of two
	always_comb begin
		push = in_valid_i & in_ready_o;
		pop = out_valid_o & out_ready_i;
		next_mem = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push) begin
			next_mem[wr_ptr] = in_data_i;
			next_wr_ptr = wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = rd_ptr + 1'b1;
		end
		next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mem <= '{default: '0};
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			mem <= next_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end
endmodule // psram_fifo
`default_nettype wire

// File: psram_device.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Select falling edge starts a transaction
// - Select rising edge ends any access
// - Host gives each slave its own select
// - Host sources clock; differential uses crossing point
// - Clock may stop between transactions
// - Command, address, data share byte lane
// - Strobe driven during command phase for latency
// - Strobe toggles with each read byte
// - Host drives strobe as write mask
// - Dual-die always uses doubled latency
// - Bus reset low reinitialises, then standby
// - Bus reset low floats lane and strobe
// - Masked write byte leaves memory unchanged
// - Strobe high means extra refresh latency
// - Select falls only with clock idle low
module psram_device
	import psram_port_pkg::*;
#(
	parameter bit DUAL_DIE = 1'b0
) (
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic        diff_clock_i,
	psram_bus_if.device      bus,
	output logic             busy_o,
	output logic             refresh_pending_o,
	output logic             write_strobe_o,
	output logic [ADDR_W-1:0] write_addr_o,
	output logic [7:0]       write_data_o
);
	// Pin synchronisers
	logic       tc_s1, tc_s2, cc_s1, cc_s2, cs_s1, cs_s2, rst_s1, rst_s2, sm_s1, sm_s2;
	logic [7:0] dq_s1, dq_s2;
	logic       lvl_prev, cs_prev;
	logic       clk_lvl, bus_edge, cs_fall, cs_rise;

	dev_state_t        state, next_state;
	logic [EDGE_W-1:0] edges, next_edges;
	logic              rw, next_rw;
	logic              long_lat, next_long_lat;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [7:0]        mem [MEM_DEPTH];
	logic [7:0]        next_mem [MEM_DEPTH];
	logic [7:0]        dq_out, next_dq_out;
	logic              dq_oe, next_dq_oe;
	logic              str_out, next_str_out;
	logic              str_oe, next_str_oe;
	logic              wr_stb, next_wr_stb;
	logic [ADDR_W-1:0] wr_addr, next_wr_addr;
	logic [7:0]        wr_data, next_wr_data;
	logic [8:0]        ref_cnt, next_ref_cnt;
	logic              ref_due, next_ref_due;
	logic              ref_set, ref_clear;
	logic [EDGE_W-1:0] lat_edges;

	// Two flops on every pin before any logic looks at it
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tc_s1 <= 1'b0;
			tc_s2 <= 1'b0;
			cc_s1 <= 1'b1;
			cc_s2 <= 1'b1;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
			sm_s1 <= 1'b0;
			sm_s2 <= 1'b0;
			dq_s1 <= 8'h00;
			dq_s2 <= 8'h00;
			lvl_prev <= 1'b0;
			cs_prev <= 1'b1;
		end else begin
			tc_s1 <= bus.bus_clock_true;
			tc_s2 <= tc_s1;
			cc_s1 <= bus.clock_complement;
			cc_s2 <= cc_s1;
			cs_s1 <= bus.cs_n;
			cs_s2 <= cs_s1;
			rst_s1 <= bus.hw_reset_n;
			rst_s2 <= rst_s1;
			sm_s1 <= bus.strobe_mask_line;
			sm_s2 <= sm_s1;
			dq_s1 <= bus.dq;
			dq_s2 <= dq_s1;
			lvl_prev <= clk_lvl;
			cs_prev <= cs_s2;
		end
	end

	// Crossing point: true above complement reads as high
	assign clk_lvl = diff_clock_i ? (tc_s2 & ~cc_s2) : tc_s2;
	assign bus_edge = (clk_lvl != lvl_prev);
	assign cs_fall = ~cs_s2 & cs_prev;
	assign cs_rise = cs_s2 & ~cs_prev;
	assign lat_edges = long_lat ? LAT2_EDGES : LAT1_EDGES;

	// Refresh request timer; a request raised as it is taken is kept
	always_comb begin
		ref_set = (ref_cnt == REFRESH_LAST);
		next_ref_cnt = ref_set ? 9'h000 : ref_cnt + 9'h001;
		next_ref_due = (ref_due & ~ref_clear) | ref_set;
	end

	// Transaction sequencer, stepped by select edges and observed bus clock edges
	always_comb begin
		next_state = state;
		next_edges = edges;
		next_rw = rw;
		next_long_lat = long_lat;
		next_addr = addr;
		next_mem = mem;
		next_dq_out = dq_out;
		next_dq_oe = dq_oe;
		next_str_out = str_out;
		next_str_oe = str_oe;
		next_wr_stb = 1'b0;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		ref_clear = 1'b0;
		case (state)
			D_IDLE: begin
				next_dq_oe = 1'b0;
				next_str_oe = 1'b0;
				if (cs_fall) begin
					next_state = D_CMD;
					next_edges = '0;
					next_long_lat = ref_due | DUAL_DIE;
					next_str_out = ref_due | DUAL_DIE;
					next_str_oe = 1'b1;
					ref_clear = ref_due;
				end
			end
			D_CMD: begin
				if (bus_edge) begin
					next_edges = edges + 6'h01;
					if (edges == '0) begin
						next_rw = dq_s2[CMD_RW_BIT];
					end
					if (edges == ADDR_BYTE) begin
						next_addr = dq_s2[ADDR_W-1:0];
						next_state = D_LAT;
						next_edges = '0;
						next_str_out = 1'b0;
						next_str_oe = rw; // Writes hand the line to the host
					end
				end
			end
			D_LAT: begin
				if (bus_edge) begin
					next_edges = edges + 6'h01;
					if (edges == lat_edges - 6'h01) begin
						next_state = rw ? D_READ : D_WRITE;
						next_edges = '0;
					end
				end
			end
			D_READ: begin
				if (bus_edge) begin
					next_dq_out = mem[addr];
					next_dq_oe = 1'b1;
					next_str_out = ~str_out;
					next_addr = addr + 1'b1;
				end
			end
			D_WRITE: begin
				if (bus_edge) begin
					next_addr = addr + 1'b1;
					if (!sm_s2) begin
						next_mem[addr] = dq_s2;
						next_wr_stb = 1'b1;
						next_wr_addr = addr;
						next_wr_data = dq_s2;
					end
				end
			end
			default: begin
				next_state = D_IDLE;
			end
		endcase
		// End of frame overrides any edge seen in the same cycle
		if (state != D_IDLE && cs_rise) begin
			next_state = D_IDLE;
			next_dq_oe = 1'b0;
			next_str_oe = 1'b0;
		end
		// Bus reset: back to standby, lane and strobe floated
		if (!rst_s2) begin
			next_state = D_IDLE;
			next_edges = '0;
			next_long_lat = 1'b0;
			next_dq_oe = 1'b0;
			next_str_oe = 1'b0;
			next_str_out = 1'b0;
			next_wr_stb = 1'b0;
		end
	end

	// Array contents survive a bus reset, only control state is cleared
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= D_IDLE;
			edges <= '0;
			rw <= 1'b0;
			long_lat <= 1'b0;
			addr <= '0;
			mem <= '{default: 8'h00};
			dq_out <= 8'h00;
			dq_oe <= 1'b0;
			str_out <= 1'b0;
			str_oe <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= '0;
			wr_data <= 8'h00;
			ref_cnt <= 9'h000;
			ref_due <= 1'b0;
		end else begin
			state <= next_state;
			edges <= next_edges;
			rw <= next_rw;
			long_lat <= next_long_lat;
			addr <= next_addr;
			mem <= next_mem;
			dq_out <= next_dq_out;
			dq_oe <= next_dq_oe;
			str_out <= next_str_out;
			str_oe <= next_str_oe;
			wr_stb <= next_wr_stb;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			ref_cnt <= next_ref_cnt;
			ref_due <= next_ref_due;
		end
	end

	// Pin drivers straight from flops
	assign bus.dq_dev = dq_out;
	assign bus.dq_dev_oe = dq_oe;
	assign bus.strobe_dev = str_out;
	assign bus.strobe_dev_oe = str_oe;
	assign busy_o = (state != D_IDLE);
	assign refresh_pending_o = ref_due;
	assign write_strobe_o = wr_stb;
	assign write_addr_o = wr_addr;
	assign write_data_o = wr_data;
endmodule // psram_device
`default_nettype wire

// File: psram_host.sv
`timescale 1ns/1ps
`default_nettype none
module psram_host
	import psram_port_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              reset_n_i,
	input  wire logic              bus_reset_req_i,
	input  wire logic              start_i,
	input  wire logic              read_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [3:0]        words_i,
	input  wire logic [7:0]        wr_data_i,
	input  wire logic              wr_mask_i,
	input  wire logic              wr_valid_i,
	output logic                   wr_ready_o,
	output logic [7:0]             rd_data_o,
	output logic                   rd_valid_o,
	output logic                   busy_o,
	output logic                   done_o,
	output logic                   extra_latency_o,
	psram_bus_if.host              bus
);
	logic [7:0]        dq_s1, dq_s2;
	logic              st_s1, st_s2, st_prev;
	host_state_t       state, next_state;
	logic [1:0]        ph, next_ph;
	logic              clk, next_clk, cs_n, next_cs_n, rst_pin, next_rst_pin;
	logic [EDGE_W-1:0] edges, next_edges, lat, total;
	logic              rw, next_rw, long_lat, next_long_lat;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [3:0]        words, next_words;
	logic [7:0]        dq, next_dq;
	logic              dq_oe, next_dq_oe, mask, next_mask, mask_oe, next_mask_oe;
	logic [4:0]        rx_cnt, next_rx_cnt;
	logic [7:0]        rd_data, next_rd_data;
	logic              rd_valid, next_rd_valid, done, next_done;
	logic [FIFO_W-1:0] f_data;
	logic              f_valid, f_pop;

	// Write bytes and masks queue here; an empty queue stalls the bus clock
	psram_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_psram_fifo (
		.mclk_i      (mclk_i),
		.reset_n_i   (reset_n_i),
		.in_data_i   ({wr_mask_i, wr_data_i}),
		.in_valid_i  (wr_valid_i),
		.in_ready_o  (wr_ready_o),
		.out_data_o  (f_data),
		.out_valid_o (f_valid),
		.out_ready_i (f_pop)
	);

	// Command bytes: read flag, memory space, linear burst, start word
	function automatic logic [7:0] cmd_byte(input logic [5:0] idx, input logic r,
		input logic [ADDR_W-1:0] a);
		logic [7:0] b;
		b = 8'h00;
		if (idx == '0) begin
			b[CMD_RW_BIT] = r;
			b[CMD_LINEAR_BIT] = 1'b1;
		end
		if (idx == ADDR_BYTE) begin
			b[ADDR_W-1:0] = a;
		end
		return b;
	endfunction

	assign lat = long_lat ? LAT2_EDGES : LAT1_EDGES;
	assign total = CMD_BYTES + lat + {1'b0, words, 1'b0};

	// Clock divider, byte setup half way between edges, read capture on strobe
	always_comb begin
		next_state = state;
		next_ph = ph;
		next_clk = clk;
		next_cs_n = cs_n;
		next_edges = edges;
		next_rw = rw;
		next_long_lat = long_lat;
		next_addr = addr;
		next_words = words;
		next_dq = dq;
		next_dq_oe = dq_oe;
		next_mask = mask;
		next_mask_oe = mask_oe;
		next_rx_cnt = rx_cnt;
		next_rd_data = rd_data;
		next_rd_valid = 1'b0;
		next_done = 1'b0;
		next_rst_pin = ~bus_reset_req_i;
		f_pop = 1'b0;
		if (rw && edges > CMD_BYTES + lat && st_s2 != st_prev
			&& rx_cnt != {words, 1'b0}) begin
			next_rd_data = dq_s2;
			next_rd_valid = 1'b1;
			next_rx_cnt = rx_cnt + 5'h01;
		end
		case (state)
			H_IDLE: begin
				if (start_i && rst_pin) begin
					next_state = H_SETUP;
					next_rw = read_i;
					next_addr = addr_i;
					next_words = words_i;
					next_long_lat = 1'b0;
					next_edges = '0;
					next_rx_cnt = 5'h00;
					next_ph = 2'h0;
					next_cs_n = 1'b0; // Clock is low here, select falls idle
					next_dq = cmd_byte(6'h00, read_i, addr_i);
					next_dq_oe = 1'b1;
				end
			end
			H_SETUP: begin
				next_ph = ph + 2'h1;
				if (ph == PH_LAST) begin
					next_state = H_RUN;
					next_ph = 2'h0;
				end
			end
			H_RUN: begin
				next_ph = (ph == PH_LAST) ? 2'h0 : ph + 2'h1;
				if (ph == 2'h0) begin
					next_clk = ~clk;
					next_edges = edges + 6'h01;
					if (edges + 6'h01 == total) begin
						next_state = rw ? H_DRAIN : H_HOLD;
					end
				end else if (ph == PH_MID) begin
					if (edges == LAT_SAMPLE) begin
						next_long_lat = st_s2;
					end
					if (edges < CMD_BYTES) begin
						next_dq = cmd_byte(edges, rw, addr);
					end else if (rw || edges < CMD_BYTES + lat) begin
						next_dq_oe = 1'b0;
						next_mask_oe = 1'b0;
					end else if (f_valid) begin
						f_pop = 1'b1;
						next_dq = f_data[7:0];
						next_mask = f_data[8];
						next_dq_oe = 1'b1;
						next_mask_oe = 1'b1;
					end else begin
						next_ph = ph; // Starved: hold the clock still
					end
				end
			end
			H_DRAIN: begin
				if (rx_cnt == {words, 1'b0}) begin
					next_state = H_HOLD;
					next_ph = PH_LAST;
				end
			end
			H_HOLD: begin
				next_ph = ph + 2'h1;
				if (ph == PH_LAST) begin
					next_state = H_GAP;
					next_ph = 2'h0;
					next_cs_n = 1'b1;
					next_dq_oe = 1'b0;
					next_mask_oe = 1'b0;
					next_done = 1'b1;
				end
			end
			H_GAP: begin
				next_ph = ph + 2'h1;
				if (ph == PH_LAST) begin
					next_state = H_IDLE;
				end
			end
			default: begin
				next_state = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dq_s1 <= 8'h00;
			dq_s2 <= 8'h00;
			st_s1 <= 1'b0;
			st_s2 <= 1'b0;
			st_prev <= 1'b0;
			state <= H_IDLE;
			ph <= 2'h0;
			clk <= 1'b0;
			cs_n <= 1'b1;
			rst_pin <= 1'b0;
			edges <= '0;
			rw <= 1'b0;
			long_lat <= 1'b0;
			addr <= '0;
			words <= 4'h0;
			dq <= 8'h00;
			dq_oe <= 1'b0;
			mask <= 1'b0;
			mask_oe <= 1'b0;
			rx_cnt <= 5'h00;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			done <= 1'b0;
		end else begin
			dq_s1 <= bus.dq;
			dq_s2 <= dq_s1;
			st_s1 <= bus.strobe_mask_line;
			st_s2 <= st_s1;
			st_prev <= st_s2;
			state <= next_state;
			ph <= next_ph;
			clk <= next_clk;
			cs_n <= next_cs_n;
			rst_pin <= next_rst_pin;
			edges <= next_edges;
			rw <= next_rw;
			long_lat <= next_long_lat;
			addr <= next_addr;
			words <= next_words;
			dq <= next_dq;
			dq_oe <= next_dq_oe;
			mask <= next_mask;
			mask_oe <= next_mask_oe;
			rx_cnt <= next_rx_cnt;
			rd_data <= next_rd_data;
			rd_valid <= next_rd_valid;
			done <= next_done;
		end
	end

	assign bus.cs_n = cs_n;
	assign bus.bus_clock_true = clk;
	assign bus.clock_complement = ~clk;
	assign bus.hw_reset_n = rst_pin;
	assign bus.dq_host = dq;
	assign bus.dq_host_oe = dq_oe;
	assign bus.mask_host = mask;
	assign bus.mask_host_oe = mask_oe;
	assign rd_data_o = rd_data;
	assign rd_valid_o = rd_valid;
	assign busy_o = (state != H_IDLE);
	assign done_o = done;
	assign extra_latency_o = long_lat;
endmodule // psram_host
`default_nettype wire

// File: psram_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module psram_port_checker (
	input wire logic       mclk_i,
	input wire logic       reset_n_i,
	input wire logic       cs_n,
	input wire logic       bus_clock_true,
	input wire logic       clock_complement,
	input wire logic       hw_reset_n,
	input wire logic       dq_dev_oe,
	input wire logic       strobe_dev_oe,
	input wire logic       dq_host_oe,
	input wire logic       mask_host_oe,
	input wire logic [7:0] dq,
	input wire logic       strobe_mask_line
);
	// One clock domain; reset of both ends quiets every check
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	// Complement always mirrors the true clock
	property p_clock_pair;
		clock_complement == !bus_clock_true;
	endproperty
	a_clock_pair: assert property (p_clock_pair)
		else $error("complement clock not inverse of true clock");

	// Select falls only with the clock parked low
	property p_select_idle;
		$fell(cs_n) |-> !bus_clock_true && clock_complement;
	endproperty
	a_select_idle: assert property (p_select_idle)
		else $error("select fell while clock not idle");

	// Between frames the clock stands still, low
	property p_clock_still;
		cs_n && $past(cs_n) |-> $stable(bus_clock_true) && !bus_clock_true;
	endproperty
	a_clock_still: assert property (p_clock_still)
		else $error("bus clock moved outside a frame");

	// Every new frame gets a latency flag from the device
	property p_start_flag;
		$fell(cs_n) && hw_reset_n |-> ##[1:6] strobe_dev_oe;
	endproperty
	a_start_flag: assert property (p_start_flag)
		else $error("no latency flag after select fall");

	// Shared lane never driven from both sides
	property p_lane_exclusive;
		!(dq_dev_oe && dq_host_oe);
	endproperty
	a_lane_exclusive: assert property (p_lane_exclusive)
		else $error("byte lane driven by both ends");

	// Write mask and device strobe never collide
	property p_strobe_exclusive;
		!(strobe_dev_oe && mask_host_oe);
	endproperty
	a_strobe_exclusive: assert property (p_strobe_exclusive)
		else $error("strobe line driven by both ends");

	// Select rise ends the access within the sync delay
	property p_end_float;
		$rose(cs_n) |-> ##[1:6] (!dq_dev_oe && !strobe_dev_oe);
	endproperty
	a_end_float: assert property (p_end_float)
		else $error("device still driving after select rise");

	// Deselected device keeps its pins floating
	property p_float_deselect;
		cs_n [*6] |-> !dq_dev_oe && !strobe_dev_oe;
	endproperty
	a_float_deselect: assert property (p_float_deselect)
		else $error("device drives while deselected");

	// Bus reset floats lane and strobe
	property p_float_reset;
		!hw_reset_n [*5] |-> !dq_dev_oe && !strobe_dev_oe;
	endproperty
	a_float_reset: assert property (p_float_reset)
		else $error("device drives during bus reset");

	// Each new read byte comes with a strobe edge
	property p_read_strobe;
		dq_dev_oe && $past(dq_dev_oe) && $changed(dq) |-> $changed(strobe_mask_line);
	endproperty
	a_read_strobe: assert property (p_read_strobe)
		else $error("read byte changed without strobe edge");
endmodule // psram_port_checker
`default_nettype wire

// File: psram_ddr_bus_signal_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
	$display("BAD %0t got %h exp %h", $time, got, exp); end end
module psram_ddr_bus_signal_port_test;
	import psram_port_pkg::*;
	logic       mclk_i;
	logic       reset_n_i;
	logic       diff_mode;
	logic       bus_reset_req;
	logic       start;
	logic       rd;
	logic [3:0] addr;
	logic [3:0] words;
	logic [7:0] wdata;
	logic       wmask;
	logic       wvalid;
	logic       wready;
	logic [7:0] rdata;
	logic       rvalid;
	logic [1:0] hbusy;
	logic       ext;
	logic       dbusy;
	logic       refresh;
	logic       wstb;
	logic       done;
	logic [3:0] waddr;
	logic [7:0] wbyte;
	logic [1:0] clk_q;
	logic [3:0] raddr;
	logic [7:0] exp_mem [16];
	int         error_cnt, checks_done, wcnt, rcnt, rises, rises2, n, dcnt;

	// Second pair uses the dual-die device; same user stimulus for both
	psram_bus_if u_psram_bus_if ();
	psram_bus_if u_psram_bus_if_dual ();
	psram_host u_psram_host (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.bus_reset_req_i(bus_reset_req), .start_i(start), .read_i(rd), .addr_i(addr),
		.words_i(words), .wr_data_i(wdata), .wr_mask_i(wmask), .wr_valid_i(wvalid),
		.wr_ready_o(wready), .rd_data_o(rdata), .rd_valid_o(rvalid), .busy_o(hbusy[0]),
		.done_o(done), .extra_latency_o(ext), .bus(u_psram_bus_if));
	psram_device #(.DUAL_DIE(1'b0)) u_psram_device (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.diff_clock_i(diff_mode), .bus(u_psram_bus_if), .busy_o(dbusy),
		.refresh_pending_o(refresh), .write_strobe_o(wstb), .write_addr_o(waddr),
		.write_data_o(wbyte));
	psram_host u_psram_host_dual (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.bus_reset_req_i(bus_reset_req), .start_i(start), .read_i(rd), .addr_i(addr),
		.words_i(words), .wr_data_i(wdata), .wr_mask_i(wmask), .wr_valid_i(wvalid),
		.wr_ready_o(), .rd_data_o(), .rd_valid_o(), .busy_o(hbusy[1]), .done_o(),
		.extra_latency_o(), .bus(u_psram_bus_if_dual));
	psram_device #(.DUAL_DIE(1'b1)) u_psram_device_dual (.mclk_i(mclk_i),
		.reset_n_i(reset_n_i), .diff_clock_i(diff_mode), .bus(u_psram_bus_if_dual),
		.busy_o(), .refresh_pending_o(), .write_strobe_o(), .write_addr_o(), .write_data_o());
	psram_port_checker u_psram_port_checker (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.cs_n(u_psram_bus_if.cs_n), .bus_clock_true(u_psram_bus_if.bus_clock_true),
		.clock_complement(u_psram_bus_if.clock_complement),
		.hw_reset_n(u_psram_bus_if.hw_reset_n), .dq_dev_oe(u_psram_bus_if.dq_dev_oe),
		.strobe_dev_oe(u_psram_bus_if.strobe_dev_oe), .dq_host_oe(u_psram_bus_if.dq_host_oe),
		.mask_host_oe(u_psram_bus_if.mask_host_oe), .dq(u_psram_bus_if.dq),
		.strobe_mask_line(u_psram_bus_if.strobe_mask_line));

	// Clock
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// Monitor on the falling edge so register outputs have settled
	always @(negedge mclk_i) begin
		if (u_psram_bus_if.bus_clock_true && !clk_q[0]) rises++;
		if (u_psram_bus_if_dual.bus_clock_true && !clk_q[1]) rises2++;
		clk_q = {u_psram_bus_if_dual.bus_clock_true, u_psram_bus_if.bus_clock_true};
		if (done === 1'b1) dcnt++;
		if (wstb === 1'b1) begin
			wcnt++;
			`CHK(wbyte, exp_mem[waddr])
		end
		if (rvalid === 1'b1) begin
			rcnt++;
			`CHK(rdata, exp_mem[raddr])
			raddr++;
		end
	end

	task automatic stop_test();
		$display("Checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic push(input logic [7:0] d, input logic m);
		@(posedge mclk_i);
		wdata <= d;
		wmask <= m;
		wvalid <= 1'b1;
		@(posedge mclk_i);
		wvalid <= 1'b0;
	endtask

	// One frame on both links; clock rises reveal the latency chosen
	task automatic run(input logic r, input logic [3:0] a, input logic [3:0] w);
		logic pend;
		@(posedge mclk_i);
		start <= 1'b1;
		rd <= r;
		addr <= a;
		words <= w;
		rises = 0;
		rises2 = 0;
		dcnt = 0;
		raddr = a;
		pend = refresh;
		@(posedge mclk_i);
		start <= 1'b0;
		n = 0;
		do begin
			@(negedge mclk_i);
			n++;
		end while (hbusy !== 2'b00 && n < 4000);
		// Three command clocks, then latency clocks, then one clock per word
		`CHK(rises, 3 + (ext ? 2 * LAT_CLOCKS : LAT_CLOCKS) + w)
		`CHK(rises2, 3 + 2 * LAT_CLOCKS + w)
		`CHK(dcnt, 1)
		if (pend === 1'b1) `CHK(ext, 1'b1)
		if (n >= 4000) begin
			error_cnt++;
			$display("BAD %0t frame did not finish", $time);
			stop_test();
		end
	endtask

	task automatic sc_idle_state();
		@(negedge mclk_i);
		`CHK(u_psram_bus_if.cs_n, 1'b1)
		`CHK({u_psram_bus_if.dq_dev_oe, u_psram_bus_if.strobe_dev_oe}, 2'b00)
		`CHK(dbusy, 1'b0)
	endtask

	// Fill the write buffer until it refuses, then drain it in one burst
	task automatic sc_fill_drain();
		n = 0;
		while (wready === 1'b1 && n < 20) begin
			exp_mem[n[3:0]] = 8'hA0 + 8'(n);
			push(8'hA0 + 8'(n), 1'b0);
			n++;
			@(negedge mclk_i);
		end
		`CHK(n, FIFO_DEPTH)
		wcnt = 0;
		run(1'b0, 4'h0, 4'h8);
		`CHK(wcnt, 16)
		`CHK(wready, 1'b1)
	endtask

	// Masked first byte must leave memory alone; read-back proves it
	task automatic sc_masked();
		exp_mem[4] = 8'h22;
		push(8'h11, 1'b1);
		push(8'h22, 1'b0);
		wcnt = 0;
		run(1'b0, 4'h3, 4'h1);
		`CHK(wcnt, 1)
		rcnt = 0;
		run(1'b1, 4'h2, 4'h2);
		`CHK(rcnt, 4)
	endtask

	// Bus reset floats the device; contents survive; idle long enough to need refresh
	task automatic sc_bus_reset();
		@(posedge mclk_i);
		diff_mode <= 1'b1;
		bus_reset_req <= 1'b1;
		repeat (8) @(negedge mclk_i);
		`CHK(u_psram_bus_if.hw_reset_n, 1'b0)
		`CHK(dbusy, 1'b0)
		`CHK({u_psram_bus_if.dq_dev_oe, u_psram_bus_if.strobe_dev_oe}, 2'b00)
		@(posedge mclk_i);
		bus_reset_req <= 1'b0;
		repeat (450) @(negedge mclk_i);
		rcnt = 0;
		run(1'b1, 4'hF, 4'h1);
		`CHK(rcnt, 2)
	endtask

	// Main sequence
	initial begin
		reset_n_i = 1'b0;
		diff_mode = 1'b0;
		bus_reset_req = 1'b0;
		start = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		words = 4'h0;
		wdata = 8'h00;
		wmask = 1'b0;
		wvalid = 1'b0;
		clk_q = 2'b00;
		repeat (20) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (6) @(negedge mclk_i);
		sc_idle_state();
		sc_fill_drain();
		sc_masked();
		sc_bus_reset();
		sc_idle_state();
		stop_test();
	end
endmodule // psram_ddr_bus_signal_port_test
`default_nettype wire
